// File: design/sscr_pkg.sv
/*
  sscr_pkg: register map, reset values and shared types of the
  start-stop code receiver.
  Assumes a 32-bit apb bus and a 100 MHz pclk.
*/
package sscr_pkg;
  // register byte offsets
  localparam logic [7:0] SSCR_CTRL_OFS  = 8'h00;
  localparam logic [7:0] SSCR_BASE_OFS  = 8'h04;
  localparam logic [7:0] SSCR_ELEM_OFS  = 8'h08;
  localparam logic [7:0] SSCR_PHASE_OFS = 8'h0c;
  localparam logic [7:0] SSCR_STAT_OFS  = 8'h10;
  localparam logic [7:0] SSCR_DATA_OFS  = 8'h14;
  localparam logic [7:0] SSCR_BAR_OFS   = 8'h18;
  // control fields
  localparam int SSCR_CTRL_EN    = 0;
  localparam int SSCR_CTRL_NOTB  = 1;
  localparam int SSCR_CTRL_NOSP  = 2;
  localparam logic [2:0] SSCR_CTRL_RST = 3'h1;
  // status fields
  localparam int SSCR_ST_RX   = 0;
  localparam int SSCR_ST_SEQ  = 1;
  localparam int SSCR_ST_LINE = 2;
  localparam int SSCR_ST_VAL  = 3;
  localparam int SSCR_ST_FULL = 4;
  localparam int SSCR_ST_ASM  = 8;
  localparam int SSCR_DATA_VAL = 9;
  // timing reset values in pclk cycles (software reprograms)
  localparam logic [31:0] SSCR_BASE_RST  = 32'h00f4_2400;
  localparam logic [31:0] SSCR_ELEM_RST  = 32'h001e_8480;
  localparam logic [31:0] SSCR_PHASE_RST = 32'h000f_4240;
  // code elements per character
  localparam logic [2:0] SSCR_NELEM = 3'h5;
  // five-element code that asks for line feed (element 2 marking)
  localparam logic [4:0] SSCR_LF_CODE = 5'h02;

  // code bar register, top to bottom
  typedef struct packed {
    logic supp;
    logic c4;
    logic c1;
    logic c5;
    logic c2;
    logic c3;
    logic common;
    logic zero;
    logic shift;
  } sscr_bar_t;

  typedef enum logic [1:0] {RX_IDLE, RX_RUN, RX_HOLD} sscr_rx_t;
  typedef enum logic [2:0] {
    SQ_IDLE, SQ_XFER, SQ_FUNC, SQ_TBOX, SQ_SPACE, SQ_LF
  } sscr_sq_t;
endpackage : sscr_pkg

// File: design/sscr_top.sv
/*
  sscr_top: start-stop five-element code receiver with code bar
  register, follow-on sequencer and a two-entry output buffer.
  Assumes an apb master on pclk and an asynchronous line input
  (1 = marking, 0 = spacing).
*/
// Operation
// R01: a marking line keeps the receiver idle, no sampling starts
// R02: a spacing start element starts one reception cycle
// R03: during a reception cycle further start detection is ignored
// R04: after the stop position the receiver idles until a new start; code waits in RX_HOLD, ignoring starts, until the character is pushed
// R05: exactly five code elements are sampled, once each
// R06: the sampled level is latched until the next element sample
// R07: a bit is selected only if its element samples marking
// R08: the assembled pattern holds until the next start element
// R09: a new start clears the assembly register first
// R10: a programmable phase offset moves the sample instant
// R11: completion of reception triggers one transfer cycle
// R12: transfer clears stale marks and sets the newly marked bits
// R13: common bit is marking when code bit 1 or 2 is marking
// R14: transfer lasts one base cycle, then the code bar holds
// R15: code bar holds nine bits in the fixed top-to-bottom order
// R16: spacing and line-feed steps last one third of a base cycle
// R17: order is reception, transfer, function, type box, spacing, lf
// R18: marking is one, first element maps to code bit 1
// R19: timing comes from programmable pclk counts per base cycle
`timescale 1ns/1ps
module sscr_top
  import sscr_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        line_in,
  output logic [8:0]       code_bar,
  output logic             elem_level,
  output logic             rx_active,
  output logic             space_step,
  output logic             lf_step
);
  // registers
  logic [2:0]  ctrl_q;
  logic [31:0] base_q, elem_q, phase_q;
  logic [31:0] prdata_q;
  logic        pready_q, pslverr_q;
  // line synchroniser
  logic        s1_q, s2_q, s3_q, line_q;
  // receiver
  sscr_rx_t    rx_q;
  logic [31:0] rt_q, samp_q;
  logic [2:0]  idx_q;
  logic [4:0]  asm_q;
  logic        lvl_q;
  // sequencer
  sscr_sq_t    sq_q;
  logic [31:0] st_q;
  sscr_bar_t   bar_q;
  logic        sp_q, lf_q;
  // two-entry buffer
  logic [8:0]  mem_q [2];
  logic        wp_q, rp_q;
  logic [1:0]  cnt_q;

  logic        acc, wr, rd, hit, push, pop, full, empty;
  logic        base_end, third_end;
  logic [31:0] rdata;

  function automatic logic known(input logic [7:0] a);
    known = (a == SSCR_CTRL_OFS) || (a == SSCR_BASE_OFS) ||
            (a == SSCR_ELEM_OFS) || (a == SSCR_PHASE_OFS) ||
            (a == SSCR_STAT_OFS) || (a == SSCR_DATA_OFS) ||
            (a == SSCR_BAR_OFS);
  endfunction : known

  // code bar word from the assembled elements, fixed bars spacing
  function automatic sscr_bar_t to_bar(input logic [4:0] a);
    to_bar        = '0;
    to_bar.c4     = a[3]; // [R15]
    to_bar.c1     = a[0];
    to_bar.c5     = a[4];
    to_bar.c2     = a[1];
    to_bar.c3     = a[2];
    to_bar.common = a[0] | a[1]; // derived, not received [R13]
  endfunction : to_bar

  // line feed decode from the code bar: the assembly may already
  // hold the next character while the sequencer still runs
  function automatic logic is_lf(input sscr_bar_t b);
    is_lf = ({b.c5, b.c4, b.c3, b.c2, b.c1} == SSCR_LF_CODE);
  endfunction : is_lf

  // apb access phase qualifiers
  assign acc  = psel && penable && pready_q;
  assign hit  = known(paddr);
  assign wr   = acc && pwrite && hit;
  assign rd   = acc && !pwrite && hit;
  assign full  = (cnt_q == 2'd2);
  assign empty = (cnt_q == 2'd0);
  // pop only a word that this read really returned as valid, so a push
  // landing between capture and pready can never be dropped unread
  assign pop  = rd && (paddr == SSCR_DATA_OFS) && prdata_q[SSCR_DATA_VAL];
  // load a finished character only when the buffer has room
  assign push = (rx_q == RX_HOLD) && (sq_q == SQ_IDLE) && !full;
  assign base_end  = (st_q >= base_q - 32'd1);
  assign third_end = ({st_q[30:0], 1'b0} + st_q + 32'd3 >= base_q);

  // pready one cycle after the access phase starts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0;
    end else begin
      pready_q  <= psel && penable && !pready_q;
      pslverr_q <= psel && penable && !pready_q && !known(paddr);
      if (psel && penable && !pready_q && !pwrite) begin
        prdata_q <= rdata;
      end
    end
  end

  // read mux
  always_comb begin
    rdata = 32'h0;
    case (paddr)
      SSCR_CTRL_OFS:  rdata = {29'h0, ctrl_q};
      SSCR_BASE_OFS:  rdata = base_q;
      SSCR_ELEM_OFS:  rdata = elem_q;
      SSCR_PHASE_OFS: rdata = phase_q;
      SSCR_STAT_OFS: begin
        rdata[SSCR_ST_RX]   = (rx_q != RX_IDLE);
        rdata[SSCR_ST_SEQ]  = (sq_q != SQ_IDLE);
        rdata[SSCR_ST_LINE] = line_q;
        rdata[SSCR_ST_VAL]  = !empty;
        rdata[SSCR_ST_FULL] = full;
        rdata[SSCR_ST_ASM +: 5] = asm_q;
      end
      SSCR_DATA_OFS: begin
        rdata[8:0] = empty ? 9'h0 : mem_q[rp_q];
        rdata[SSCR_DATA_VAL] = !empty;
      end
      SSCR_BAR_OFS:   rdata = {23'h0, bar_q};
      default:        rdata = 32'h0;
    endcase
  end

  // writable configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q  <= SSCR_CTRL_RST;
      base_q  <= SSCR_BASE_RST;
      elem_q  <= SSCR_ELEM_RST;
      phase_q <= SSCR_PHASE_RST;
    end else if (wr) begin
      case (paddr)
        SSCR_CTRL_OFS:  ctrl_q  <= pwdata[2:0];
        SSCR_BASE_OFS:  base_q  <= pwdata; // [R19]
        SSCR_ELEM_OFS:  elem_q  <= pwdata; // [R19]
        SSCR_PHASE_OFS: phase_q <= pwdata; // [R10]
        default: ;
      endcase
    end
  end

  // three-stage line synchroniser, change taken when 2 and 3 agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q   <= 1'b1;
      s2_q   <= 1'b1;
      s3_q   <= 1'b1;
      line_q <= 1'b1;
    end else begin
      s1_q <= line_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        line_q <= s3_q; // marking = 1 [R18]
      end
    end
  end

  // reception cycle state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_q <= RX_IDLE;
    end else begin
      case (rx_q)
        RX_IDLE: begin
          // only a spacing level leaves idle [R01] [R02]
          if (ctrl_q[SSCR_CTRL_EN] && !line_q) begin
            rx_q <= RX_RUN;
          end
        end
        RX_RUN: begin
          // line ignored for start until the cycle ends [R03]
          if (idx_q == SSCR_NELEM && rt_q >= base_q - 32'd1) begin
            rx_q <= RX_HOLD; // stop position reached [R04] [R11]
          end
        end
        RX_HOLD: begin
          if (push) begin
            rx_q <= RX_IDLE; // wait for next start [R04]
          end
        end
        default: rx_q <= RX_IDLE;
      endcase
    end
  end

  // cycle time and next sample instant
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rt_q   <= 32'h0;
      samp_q <= 32'h0;
      idx_q  <= 3'h0;
    end else if (rx_q == RX_IDLE) begin
      rt_q   <= 32'h0;
      samp_q <= elem_q + phase_q; // first element sample [R10] [R19]
      idx_q  <= 3'h0;
    end else if (rx_q == RX_RUN) begin
      rt_q <= rt_q + 32'd1;
      if (idx_q != SSCR_NELEM && rt_q == samp_q) begin
        samp_q <= samp_q + elem_q;
        idx_q  <= idx_q + 3'd1; // five samples only [R05]
      end
    end
  end

  // assembly register and latched element level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      asm_q <= 5'h0;
      lvl_q <= 1'b1;
    end else if (rx_q == RX_IDLE && ctrl_q[SSCR_CTRL_EN] && !line_q) begin
      asm_q <= 5'h0; // clear old selections on start [R09]
    end else if (rx_q == RX_RUN && idx_q != SSCR_NELEM &&
                 rt_q == samp_q) begin
      lvl_q <= line_q; // held until next sample [R06]
      // element n lands in bit n-1, marking selects [R07] [R18]
      asm_q[idx_q] <= line_q;
    end
    // otherwise pattern held until next start [R08]
  end

  // follow-on sequencer: transfer, function, type box, spacing, lf
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sq_q <= SQ_IDLE;
      st_q <= 32'h0;
    end else begin
      st_q <= st_q + 32'd1;
      case (sq_q)
        SQ_IDLE: begin
          st_q <= 32'h0;
          if (push) begin
            sq_q <= SQ_XFER; // [R11] [R17]
          end
        end
        SQ_XFER: begin
          if (base_end) begin
            sq_q <= SQ_FUNC; // one base cycle [R14]
            st_q <= 32'h0;
          end
        end
        SQ_FUNC: begin
          if (base_end) begin
            st_q <= 32'h0;
            if (!ctrl_q[SSCR_CTRL_NOTB]) begin
              sq_q <= SQ_TBOX; // [R17]
            end else if (!ctrl_q[SSCR_CTRL_NOSP]) begin
              sq_q <= SQ_SPACE;
            end else if (is_lf(bar_q)) begin
              sq_q <= SQ_LF;
            end else begin
              sq_q <= SQ_IDLE;
            end
          end
        end
        SQ_TBOX: begin
          if (base_end) begin
            st_q <= 32'h0;
            if (!ctrl_q[SSCR_CTRL_NOSP]) begin
              sq_q <= SQ_SPACE; // [R17]
            end else if (is_lf(bar_q)) begin
              sq_q <= SQ_LF;
            end else begin
              sq_q <= SQ_IDLE;
            end
          end
        end
        SQ_SPACE: begin
          if (third_end) begin
            st_q <= 32'h0; // stops after one third [R16]
            sq_q <= is_lf(bar_q) ? SQ_LF : SQ_IDLE;
          end
        end
        SQ_LF: begin
          if (third_end) begin
            sq_q <= SQ_IDLE; // [R16]
          end
        end
        default: sq_q <= SQ_IDLE;
      endcase
    end
  end

  // code bar register, loaded once per transfer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bar_q <= '0;
    end else if (push) begin
      // whole word replaced: stale marks drop, new marks set [R12]
      bar_q <= to_bar(asm_q);
    end
    // held while the next character assembles [R14]
  end

  // sub-step pulses, one per third-cycle stop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sp_q <= 1'b0;
      lf_q <= 1'b0;
    end else begin
      sp_q <= (sq_q == SQ_SPACE) && third_end; // [R16]
      lf_q <= (sq_q == SQ_LF) && third_end;
    end
  end

  // two-entry buffer of code bar words, popped by data reads
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_q  <= 1'b0;
      rp_q  <= 1'b0;
      cnt_q <= 2'd0;
    end else begin
      if (push) begin
        wp_q <= ~wp_q;
      end
      if (pop) begin
        rp_q <= ~rp_q;
      end
      case ({push, pop})
        2'b10:   cnt_q <= cnt_q + 2'd1;
        2'b01:   cnt_q <= cnt_q - 2'd1;
        default: cnt_q <= cnt_q;
      endcase
    end
  end

  // buffer storage, same word as the code bar load
  always_ff @(posedge pclk) begin
    if (push) begin
      mem_q[wp_q] <= to_bar(asm_q);
    end
  end

  // outputs, all from flops
  assign prdata     = prdata_q;
  assign pready     = pready_q;
  assign pslverr    = pslverr_q;
  assign code_bar   = bar_q;
  assign elem_level = lvl_q;
  assign space_step = sp_q;
  assign lf_step    = lf_q;

  // active flag registered for a clean output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_active <= 1'b0;
    end else begin
      rx_active <= (rx_q == RX_RUN);
    end
  end
endmodule : sscr_top

// File: bench/sscr_top_sva.sv
/*
  sscr_chk: port assertions and covers for sscr_top.
  Assumes it is bound to sscr_top and sees one pclk domain.
*/
`timescale 1ns/1ps
module sscr_chk
  import sscr_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        line_in,
  input wire logic [8:0]  code_bar,
  input wire logic        elem_level,
  input wire logic        rx_active,
  input wire logic        space_step,
  input wire logic        lf_step
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // code bar word contents
  a_common_bit: assert property (
    code_bar[2] == (code_bar[6] | code_bar[4]))
    else $error("common bit differs from c1 or c2");
  a_fixed_bits: assert property (
    code_bar[8] == 1'b0 && code_bar[1:0] == 2'h0)
    else $error("unreceived code bar bits set");
  a_bar_hold: assert property (
    !$stable(code_bar) |=> $stable(code_bar)[*8])
    else $error("code bar changed inside a transfer");
  // receiver start and length
  a_idle_mark: assert property (line_in[*8] |-> !$rose(rx_active))
    else $error("reception began on a marking line");
  a_rx_length: assert property ($rose(rx_active) |=> rx_active[*8])
    else $error("reception cycle cut short");
  a_step_pulse: assert property ((space_step || lf_step)
    |=> !(space_step || lf_step)) else $error("step pulse too long");
  // register bus handshake
  a_apb_wait: assert property ($rose(penable) && psel |=> pready)
    else $error("pready not one cycle after access");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held over two cycles");
  a_unmapped_err: assert property (pready && !pwrite && paddr > 8'h18
    |-> pslverr && prdata == 32'h0) else $error("unmapped read accepted");

  c_bar_load: cover property (!$stable(code_bar));
  c_line_feed: cover property (lf_step);
  c_bus_error: cover property (pslverr);
endmodule : sscr_chk

bind sscr_top sscr_chk chk_u (.pclk, .presetn, .paddr, .psel, .penable,
  .pwrite, .pwdata, .prdata, .pready, .pslverr, .line_in, .code_bar,
  .elem_level, .rx_active, .space_step, .lf_step);

// File: bench/sscr_line_src.sv
/*
  sscr_line_src: remote start-stop sender driving the line loop.
  Assumes calls to send come right after a rising pclk edge.
*/
`timescale 1ns/1ps
module sscr_line_src #(
  parameter int ELEM = 16
) (
  input  wire logic pclk,
  output logic      line_in
);
  // closed loop between characters reads marking
  initial line_in = 1'b1;

  // start, five elements first bit first, stop
  task automatic send(input logic [4:0] code);
    logic [6:0] f;
    f = {1'b1, code, 1'b0};
    for (int i = 0; i < 7; i++) begin
      line_in <= f[i];
      repeat (ELEM) @(posedge pclk);
    end
  endtask : send
endmodule : sscr_line_src

// File: bench/sscr_top_test.sv
/*
  sscr_top_test: apb sequences and line characters for sscr_top.
  Assumes sscr_chk is bound and the line sender uses 16-cycle elements.
*/
`timescale 1ns/1ps
module sscr_top_test;
  import sscr_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        line_in, elem_level, rx_active, space_step, lf_step, err;
  logic [8:0]  code_bar;
  logic [4:0]  codes [5] = '{5'h00, 5'h1f, 5'h02, 5'h15, 5'h0a};
  int          fails = 0;
  int          total_checks = 0;
  int          cyc = 0;
  int          sp_n = 0;
  int          lf_n = 0;
  int          rx_n = 0;
  int          e_sp = 0;
  int          e_lf = 0;
  int          e_rx = 0;
  logic        rx_d = 1'b0;

  sscr_top dut_u (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .line_in, .code_bar,
    .elem_level, .rx_active, .space_step, .lf_step);
  sscr_line_src #(.ELEM(16)) src_u (.pclk, .line_in);

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic        wr,
                     input logic [7:0]  a,
                     input logic [31:0] wd);
    psel    <= 1'b1;
    paddr   <= a;
    pwrite  <= wr;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // no timeout here: a missing pready is caught by the hang guard
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // one idle edge so a following call never re-drives in this step
    @(posedge pclk);
  endtask : apb

  function automatic logic [8:0] bar(input logic [4:0] c);
    return {1'b0, c[3], c[0], c[4], c[1], c[2], c[0] | c[1], 2'h0};
  endfunction : bar

  // send one character and let the follow-on sequence finish
  task automatic xchar(input logic [4:0] c);
    src_u.send(c);
    repeat (700) @(posedge pclk);
  endtask : xchar

  // hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      conclude();
    end
  end

  // count step pulses and reception starts seen on the outputs
  always @(posedge pclk) begin
    rx_d <= rx_active;
    if (space_step === 1'b1) begin
      sp_n <= sp_n + 1;
    end
    if (lf_step === 1'b1) begin
      lf_n <= lf_n + 1;
    end
    if (rx_active === 1'b1 && rx_d === 1'b0) begin
      rx_n <= rx_n + 1;
    end
  end

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b0, SSCR_CTRL_OFS, 32'h0);
    chk("ctrl", rd, {29'h0, SSCR_CTRL_RST});
    apb(1'b0, SSCR_ELEM_OFS, 32'h0);
    chk("elem", rd, SSCR_ELEM_RST);
    apb(1'b0, SSCR_PHASE_OFS, 32'h0);
    chk("phase", rd, SSCR_PHASE_RST);
    apb(1'b0, 8'h1c, 32'h5);
    chk("unmapped", {err, rd[30:0]}, 32'h8000_0000);
    apb(1'b1, SSCR_BASE_OFS, 32'h78);
    apb(1'b1, SSCR_ELEM_OFS, 32'h10);
    apb(1'b1, SSCR_PHASE_OFS, 32'h8);
    apb(1'b0, SSCR_BASE_OFS, 32'h0);
    chk("base", rd, 32'h78);
    foreach (codes[i]) begin
      xchar(codes[i]);
      e_rx++;
      e_sp++;
      if (codes[i] == SSCR_LF_CODE) begin
        e_lf++;
      end
      chk("bar", code_bar, bar(codes[i]));
      chk("level", elem_level, codes[i][4]);
      chk("starts", rx_n, e_rx);
      chk("space steps", sp_n, e_sp);
      chk("lf steps", lf_n, e_lf);
      apb(1'b0, SSCR_STAT_OFS, 32'h0);
      chk("asm", rd[SSCR_ST_ASM +: 5], codes[i]);
      apb(1'b0, SSCR_DATA_OFS, 32'h0);
      chk("data", rd[9:0], {1'b1, bar(codes[i])});
    end
    // fill the buffer, stall the third character, then drain
    apb(1'b1, SSCR_CTRL_OFS, 32'h7);
    xchar(5'h01);
    xchar(5'h10);
    apb(1'b0, SSCR_STAT_OFS, 32'h0);
    chk("full", rd[SSCR_ST_FULL], 32'h1);
    xchar(5'h04);
    chk("bar held", code_bar, bar(5'h10));
    chk("suppressed", sp_n + lf_n, e_sp + e_lf);
    apb(1'b0, SSCR_DATA_OFS, 32'h0);
    chk("pop a", rd[9:0], {1'b1, bar(5'h01)});
    repeat (700) @(posedge pclk);
    chk("bar late", code_bar, bar(5'h04));
    chk("starts late", rx_n, e_rx + 3);
    apb(1'b0, SSCR_DATA_OFS, 32'h0);
    chk("pop b", rd[9:0], {1'b1, bar(5'h10)});
    apb(1'b0, SSCR_DATA_OFS, 32'h0);
    chk("pop c", rd[9:0], {1'b1, bar(5'h04)});
    apb(1'b0, SSCR_DATA_OFS, 32'h0);
    chk("empty", rd[9], 32'h0);
    conclude();
  end
endmodule : sscr_top_test
